// ---- src/pbps_mod_counter.sv ----
// modulo counter with synchronous clear; pulses done for one cycle on each wrap
// assumes lim is held stable while counting and is at least 1
`timescale 1ns/1ps
module pbps_mod_counter #(
   parameter int W = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] lim,
   output logic done
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } pbps_cnt_t;

   pbps_cnt_t s_q;
   pbps_cnt_t s_d;

   // count enables, wrap at lim-1; clear restarts the interval at zero
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      if (clr) begin
         s_d.cnt = '0;
      end else if (en) begin
         if (s_q.cnt == lim - W'(1)) begin
            s_d.cnt = '0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;

endmodule : pbps_mod_counter

// ---- src/pbps_pkg.sv ----
// types of the push-button power sequencer
// assumes nothing beyond a SystemVerilog compiler
package pbps_pkg;

   // sequencer states, binary codes written out
   typedef enum logic [2:0] {
      S_WAIT_RAIL = 3'b000,
      S_STRAP_QUAL = 3'b001,
      S_OFF = 3'b010,
      S_ON_QUAL = 3'b011,
      S_ON = 3'b100,
      S_OFF_QUAL = 3'b101,
      S_WARN = 3'b110
   } pbps_state_t;

   // whole state of the sequencer
   typedef struct packed {
      pbps_state_t state;
      logic btnPrev;
      logic intEn;
      logic warnOe;
      logic [2:0] convEn;
      logic sw1;
      logic sw2;
      logic pgFault;
   } pbps_seq_t;

endpackage : pbps_pkg

// ---- src/pbps_regs.svh ----
// constants of the push-button power sequencer: timing figures and reset levels
// assumes a single 200 MHz core clock; no software-visible registers exist
`ifndef PBPS_REGS_SVH
`define PBPS_REGS_SVH

// core clock rate
`define PBPS_CLK_MHZ 200
// time base: one internal oscillator tick, in ns
`define PBPS_TICK_NS 1000000
// cycles per tick, derived from rate and tick length
`define PBPS_TICK_CYCLES ((`PBPS_TICK_NS * `PBPS_CLK_MHZ) / 1000)
// qualification, warning and watchdog intervals, in ms
`define PBPS_QUAL_MS 20
`define PBPS_WARN_MS 1024
`define PBPS_WD_MS 11
// converter switching rate in kHz, and the half period in cycles
`define PBPS_SW_KHZ 500
`define PBPS_SW_HALF_CYCLES ((`PBPS_CLK_MHZ * 1000) / (2 * `PBPS_SW_KHZ))
// reset levels
`define PBPS_BTN_RST 1'b1
`define PBPS_SW1_RST 1'b0
`define PBPS_SW2_RST 1'b1

`endif

// ---- src/pbps_sequencer.sv ----
// push-button power sequencer: button qualification, shutdown warning,
// internal converter enable, out-of-phase switching clocks, power-good watchdog
// assumes button, rail and pin inputs are synchronous to core_clk
`timescale 1ns/1ps
`include "pbps_regs.svh"

module pbps_sequencer #(
   parameter int TICK_CYCLES = `PBPS_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic buttonIn,
   input wire logic railOk,
   input wire logic [2:0] convEnPin,
   input wire logic [2:0] convPgood,
   output logic warnOut,
   output logic warnOe,
   output logic internalEnable,
   output logic [2:0] convEnable,
   output logic swClk1,
   output logic swClk2,
   output logic pgoodFault
);

   // ****************************************************************
   // interval timers
   // ****************************************************************

   pbps_pkg::pbps_seq_t s_q;
   pbps_pkg::pbps_seq_t s_d;
   logic fallEdge;
   logic timedState;
   logic qualClr;
   logic qualTick;
   logic qualDone;
   logic [10:0] qualLim;
   logic wdActive;
   logic wdTick;
   logic wdDone;
   logic swDone;

   // the prescaler is cleared with the interval so the first tick is a whole one
   assign timedState = (s_q.state == pbps_pkg::S_STRAP_QUAL) || (s_q.state == pbps_pkg::S_ON_QUAL)
                       || (s_q.state == pbps_pkg::S_OFF_QUAL) || (s_q.state == pbps_pkg::S_WARN);
   assign qualClr = (s_d.state != s_q.state) || !timedState;
   assign qualLim = (s_q.state == pbps_pkg::S_WARN) ? 11'(`PBPS_WARN_MS) : 11'(`PBPS_QUAL_MS);

   pbps_mod_counter #(.W(18)) u_qual_pre (
      .core_clk(core_clk),
      .nrst(nrst),
      .clr(qualClr),
      .en(1'b1),
      .lim(18'(TICK_CYCLES)),
      .done(qualTick)
   );

   pbps_mod_counter #(.W(11)) u_qual_ms (
      .core_clk(core_clk),
      .nrst(nrst),
      .clr(qualClr),
      .en(qualTick),
      .lim(qualLim),
      .done(qualDone)
   );

   // watchdog runs while any enabled converter lacks power-good
   assign wdActive = s_q.intEn && ((s_q.convEn & ~convPgood) != 3'h0);

   pbps_mod_counter #(.W(18)) u_wd_pre (
      .core_clk(core_clk),
      .nrst(nrst),
      .clr(!wdActive),
      .en(1'b1),
      .lim(18'(TICK_CYCLES)),
      .done(wdTick)
   );

   pbps_mod_counter #(.W(4)) u_wd_ms (
      .core_clk(core_clk),
      .nrst(nrst),
      .clr(!wdActive),
      .en(wdTick),
      .lim(4'(`PBPS_WD_MS)),
      .done(wdDone)
   );

   // half-period divider for the switching clocks
   pbps_mod_counter #(.W(9)) u_sw_div (
      .core_clk(core_clk),
      .nrst(nrst),
      .clr(1'b0),
      .en(1'b1),
      .lim(9'(`PBPS_SW_HALF_CYCLES)),
      .done(swDone)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************

   // inputs are synchronous, so one stored sample gives the edge
   assign fallEdge = s_q.btnPrev && !buttonIn;

   always_comb begin
      s_d = s_q;
      s_d.btnPrev = buttonIn;
      if (!railOk) begin
         // rail loss is a power recycle: enable and warning off, switching clocks keep running, re-sample on return
         s_d.state = pbps_pkg::S_WAIT_RAIL;
         s_d.intEn = 1'b0;
         s_d.warnOe = 1'b0;
      end else begin
         case (s_q.state)
            pbps_pkg::S_WAIT_RAIL: begin
               if (buttonIn) begin
                  s_d.state = pbps_pkg::S_OFF;
               end else begin
                  s_d.state = pbps_pkg::S_STRAP_QUAL;
               end
            end
            pbps_pkg::S_STRAP_QUAL: begin
               if (buttonIn) begin
                  s_d.state = pbps_pkg::S_OFF;
               end else if (qualDone) begin
                  s_d.state = pbps_pkg::S_ON;
                  s_d.intEn = 1'b1;
               end
            end
            pbps_pkg::S_OFF: begin
               if (fallEdge) begin
                  s_d.state = pbps_pkg::S_ON_QUAL;
               end
            end
            pbps_pkg::S_ON_QUAL: begin
               if (buttonIn) begin
                  s_d.state = pbps_pkg::S_OFF;
               end else if (qualDone) begin
                  s_d.state = pbps_pkg::S_ON;
                  s_d.intEn = 1'b1;
               end
            end
            pbps_pkg::S_ON: begin
               if (fallEdge) begin
                  s_d.state = pbps_pkg::S_OFF_QUAL;
               end
            end
            pbps_pkg::S_OFF_QUAL: begin
               if (buttonIn) begin
                  s_d.state = pbps_pkg::S_ON;
               end else if (qualDone) begin
                  s_d.state = pbps_pkg::S_WARN;
                  s_d.warnOe = 1'b1;
               end
            end
            pbps_pkg::S_WARN: begin
               // no abort: once warned, the host is owed a shutdown
               if (qualDone) begin
                  s_d.state = pbps_pkg::S_OFF;
                  s_d.intEn = 1'b0;
                  s_d.warnOe = 1'b0;
               end
            end
            default: begin
               s_d.state = pbps_pkg::S_WAIT_RAIL;
               s_d.intEn = 1'b0;
               s_d.warnOe = 1'b0;
            end
         endcase
      end
      // converter gating: internal enable overrides each pin
      s_d.convEn = s_q.intEn ? convEnPin : 3'h0;
      // both clocks flip on the same edge, always opposite
      if (swDone) begin
         s_d.sw1 = !s_q.sw1;
         s_d.sw2 = s_q.sw1;
      end
      // fault is sticky until the internal enable drops; a new expiry wins
      if (wdDone) begin
         s_d.pgFault = 1'b1;
      end else if (!s_q.intEn) begin
         s_d.pgFault = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_q.state <= pbps_pkg::S_WAIT_RAIL;
         s_q.btnPrev <= `PBPS_BTN_RST;
         s_q.intEn <= 1'b0;
         s_q.warnOe <= 1'b0;
         s_q.convEn <= 3'h0;
         s_q.sw1 <= `PBPS_SW1_RST;
         s_q.sw2 <= `PBPS_SW2_RST;
         s_q.pgFault <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // open drain: only ever pulls low
   assign warnOut = 1'b0;
   assign warnOe = s_q.warnOe;
   assign internalEnable = s_q.intEn;
   assign convEnable = s_q.convEn;
   assign swClk1 = s_q.sw1;
   assign swClk2 = s_q.sw2;
   assign pgoodFault = s_q.pgFault;

   // ****************************************************************
   // assertions
   // ****************************************************************

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   property p_on_start;
      (railOk && s_q.state == pbps_pkg::S_OFF && fallEdge) |=> s_q.state == pbps_pkg::S_ON_QUAL;
   endproperty
   a_on_start: assert property (p_on_start) else $error("falling edge while off did not start qualification");

   property p_enable_cause;
      $rose(s_q.intEn) |-> $past(qualDone) && ($past(s_q.state) == pbps_pkg::S_ON_QUAL
                                                || $past(s_q.state) == pbps_pkg::S_STRAP_QUAL);
   endproperty
   a_enable_cause: assert property (p_enable_cause) else $error("enable rose without a qualified press");

   property p_off_start;
      (railOk && s_q.state == pbps_pkg::S_ON && fallEdge) |=> s_q.state == pbps_pkg::S_OFF_QUAL;
   endproperty
   a_off_start: assert property (p_off_start) else $error("falling edge while on did not start off qualification");

   property p_warn_hold;
      $rose(s_q.warnOe) |-> $past(s_q.state) == pbps_pkg::S_OFF_QUAL ##0 s_q.warnOe[*8];
   endproperty
   a_warn_hold: assert property (p_warn_hold) else $error("warning not raised from off qualification or dropped early");

   property p_disable_after_warn;
      ($fell(s_q.intEn) && railOk) |-> $past(s_q.warnOe) && !s_q.warnOe;
   endproperty
   a_disable_after_warn: assert property (p_disable_after_warn) else $error("enable fell without warning");

   property p_gate;
      !$past(s_q.intEn) |-> convEnable == 3'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("converter enabled while internal enable low");

   property p_follow_pin;
      $past(s_q.intEn) |-> convEnable == $past(convEnPin);
   endproperty
   a_follow_pin: assert property (p_follow_pin) else $error("converter enable does not follow its pin");

   property p_stay_off;
      (railOk && s_q.state == pbps_pkg::S_OFF && !fallEdge) |=> s_q.state == pbps_pkg::S_OFF;
   endproperty
   a_stay_off: assert property (p_stay_off) else $error("left off state without falling edge");

   property p_antiphase;
      (swClk1 != swClk2) && ($changed(swClk1) == $changed(swClk2));
   endproperty
   a_antiphase: assert property (p_antiphase) else $error("switching clocks not in antiphase");

   property p_abandon;
      (railOk && buttonIn && s_q.state == pbps_pkg::S_ON_QUAL) |=> s_q.state == pbps_pkg::S_OFF;
   endproperty
   a_abandon: assert property (p_abandon) else $error("released press not abandoned");

   property p_wd_fault;
      $rose(s_q.pgFault) |-> $past(wdDone) && $past(s_q.intEn);
   endproperty
   a_wd_fault: assert property (p_wd_fault) else $error("fault raised without watchdog expiry");

   c_power_on: cover property ($rose(s_q.intEn));
   c_warn: cover property ($rose(s_q.warnOe));
   c_shutdown: cover property ($fell(s_q.intEn) && railOk);
   c_abandon: cover property (s_q.state == pbps_pkg::S_ON_QUAL ##1 s_q.state == pbps_pkg::S_OFF);

endmodule : pbps_sequencer

// ---- verification/pbps_button_model.sv ----
// behavioural push button and host warning line for the sequencer bench
// assumes the bench calls fall and rise to act as the operator
`timescale 1ns/1ps
module pbps_button_model (
   input wire logic core_clk,
   input wire logic warnOut,
   input wire logic warnOe,
   output logic buttonIn,
   output logic warnLine
);
   // button rests high; a press pulls it to ground
   initial begin
      buttonIn = 1'b1;
   end

   // host side pull-up: the line is low only while the device drives it
   assign warnLine = warnOe ? warnOut : 1'b1;

   // press: level changes just after an edge and stays until rise is called
   task automatic fall;
      @(posedge core_clk);
      buttonIn <= 1'b0;
   endtask : fall

   // release back to the idle high level
   task automatic rise;
      @(posedge core_clk);
      buttonIn <= 1'b1;
   endtask : rise
endmodule : pbps_button_model

// ---- verification/push_button_power_sequencer_tb.sv ----
// self-checking bench for the push-button power sequencer
// assumes a short tick parameter so that the long intervals stay cheap
`timescale 1ns/1ps
`include "pbps_regs.svh"
module push_button_power_sequencer_tb;
   localparam int TICK = 10;
   localparam int QUAL = `PBPS_QUAL_MS * TICK;
   localparam int WARN = `PBPS_WARN_MS * TICK;
   localparam int WDOG = `PBPS_WD_MS * TICK;
   logic core_clk, nrst, buttonIn, railOk, warnOut, warnOe, internalEnable;
   logic swClk1, swClk2, pgoodFault, warnLine, prevSw;
   logic [2:0] convEnPin, convPgood, convEnable;
   int failures, nCompared, n, tog, same;

   pbps_sequencer #(.TICK_CYCLES(TICK)) dut_u (.core_clk(core_clk), .nrst(nrst), .buttonIn(buttonIn),
      .railOk(railOk), .convEnPin(convEnPin), .convPgood(convPgood), .warnOut(warnOut), .warnOe(warnOe),
      .internalEnable(internalEnable), .convEnable(convEnable), .swClk1(swClk1), .swClk2(swClk2),
      .pgoodFault(pgoodFault));
   pbps_button_model btn_u (.core_clk(core_clk), .warnOut(warnOut), .warnOe(warnOe), .buttonIn(buttonIn),
      .warnLine(warnLine));

   // ************************************
   // helpers
   // ************************************
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : cyc

   // wide enough that a count is never cut before it is compared
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   function automatic logic pick(input int sel);
      case (sel)
         0: return internalEnable;
         1: return warnOe;
         default: return pgoodFault;
      endcase
   endfunction : pick

   function automatic logic [2:0] inWin(input int k, input int lo, input int hi);
      return (k >= lo && k <= hi) ? 3'h1 : 3'h0;
   endfunction : inWin

   // gated enable as the pins and internal enable demand
   function automatic logic [2:0] expEn(input logic ie, input logic [2:0] pin);
      return ie ? pin : 3'h0;
   endfunction : expEn

   // bounded wait: a hang shows up as a count outside its window
   task automatic waitFor(input int sel, input logic val, input int lim, output int cnt);
      cnt = 0;
      while (pick(sel) !== val && cnt < lim) begin
         cyc(1);
         cnt++;
      end
   endtask : waitFor

   task automatic powerOn;
      btn_u.fall();
      #1;
      waitFor(0, 1'b1, QUAL + 20, n);
      chk("on delay", inWin(n, QUAL, QUAL + 8), 3'h1);
      btn_u.rise();
      cyc(2);
   endtask : powerOn

   task automatic test_done;
      $display("compared %0d mismatches %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   // hang guard, about twice the expected run length of some 15000 cycles
   initial begin
      #150000;
      failures++;
      test_done();
   end

   // ************************************
   // scenarios
   // ************************************
   initial begin
      failures = 0;
      nCompared = 0;
      nrst = 1'b0;
      railOk = 1'b0;
      convEnPin = 3'h7;
      convPgood = 3'h7;
      void'($urandom(65));
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      railOk <= 1'b1;
      cyc(QUAL + 20);
      chk("idle enable", 3'(internalEnable), 3'h0);
      // presses released early must leave the unit off
      for (int i = 0; i < 3; i++) begin
         btn_u.fall();
         cyc(1 + int'($urandom % (QUAL - 10)));
         btn_u.rise();
         cyc(QUAL + 20);
         chk("short on press", 3'(internalEnable), 3'h0);
      end
      powerOn();
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         convEnPin <= 3'($urandom);
         cyc(2);
         chk("converter enables", convEnable, expEn(internalEnable, convEnPin));
      end
      // switching clocks: opposite at every sample, fixed half period
      tog = 0;
      same = 0;
      prevSw = swClk1;
      for (int i = 0; i < 1000; i++) begin
         cyc(1);
         tog += (swClk1 !== prevSw);
         same += (swClk1 === swClk2);
         prevSw = swClk1;
      end
      chk("switch toggles", tog, 1000 / `PBPS_SW_HALF_CYCLES);
      chk("switch in phase", same, 0);
      btn_u.fall();
      cyc(QUAL / 2);
      btn_u.rise();
      cyc(QUAL + 20);
      chk("short off press", 3'(internalEnable), 3'h1);
      // qualified off press, then chatter during the warning span
      @(posedge core_clk);
      convEnPin <= 3'h7;
      btn_u.fall();
      #1;
      waitFor(1, 1'b1, QUAL + 20, n);
      chk("warn delay", inWin(n, QUAL, QUAL + 8), 3'h1);
      chk("warn line", 3'(warnLine), 3'h0);
      fork
         waitFor(0, 1'b0, WARN + 20, n);
         begin
            btn_u.rise();
            cyc(100);
            btn_u.fall();
            cyc(300);
            btn_u.rise();
         end
      join
      chk("shutdown delay", inWin(n, WARN - 2, WARN + 6), 3'h1);
      chk("warn released", 3'(warnOe), 3'h0);
      cyc(1);
      chk("forced off", convEnable, 3'h0);
      cyc(QUAL + 50);
      chk("stays off", 3'(internalEnable), 3'h0);
      chk("pins overridden", convEnable, 3'h0);
      // watchdog: a good spell clears the count, then a full span faults
      powerOn();
      @(posedge core_clk);
      convPgood <= 3'h0;
      cyc(WDOG / 2);
      @(posedge core_clk);
      convPgood <= 3'h7;
      cyc(5);
      @(posedge core_clk);
      convPgood <= 3'h5;
      #1;
      waitFor(2, 1'b1, WDOG + 20, n);
      chk("watchdog delay", inWin(n, WDOG, WDOG + 6), 3'h1);
      // power recycle with the button strapped low
      @(posedge core_clk);
      railOk <= 1'b0;
      convPgood <= 3'h7;
      cyc(3);
      chk("recycle off", 3'(internalEnable), 3'h0);
      chk("fault cleared", 3'(pgoodFault), 3'h0);
      btn_u.fall();
      cyc(5);
      @(posedge core_clk);
      railOk <= 1'b1;
      #1;
      waitFor(0, 1'b1, QUAL + 20, n);
      chk("strap delay", inWin(n, QUAL, QUAL + 8), 3'h1);
      cyc(QUAL + 50);
      chk("strap stays on", 3'(internalEnable), 3'h1);
      test_done();
   end
endmodule : push_button_power_sequencer_tb
